// ==== shared/tcs_defs.svh ====
// tcs_defs.svh: offsets, field positions, reset values and constants of the touch calibration store
// assumes a 32-bit register port with byte addresses on 8 address bits
`ifndef TCS_DEFS_SVH
`define TCS_DEFS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define TCS_OFS_XFORM_A 8'h00 // first of six transform words, a..f at +4 steps
`define TCS_OFS_XFORM_F 8'h14 // last transform word
`define TCS_OFS_CMD_READ 8'h18 // command read pointer, read only
`define TCS_OFS_CMD_WRITE 8'h1C // command write pointer
`define TCS_OFS_TOUCH_MODE 8'h20 // bit 0: extended touch mode
`define TCS_OFS_STATUS 8'h24 // busy, calibrating, target index
`define TCS_OFS_TOUCH_XY 8'h28 // last corrected touch {y, x}
`define TCS_OFS_CMD_RAM 8'h40 // eight command words, 0x40..0x5c
`define TCS_CMD_RAM_MASK 8'hE0 // decode mask for the command window

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define TCS_STAT_BUSY 0
`define TCS_STAT_CAL 1
`define TCS_STAT_PT_LSB 2
`define TCS_MODE_EXT 0

// ------------------------------------------------------------
// command codes, reset values, constants
// ------------------------------------------------------------
`define TCS_CMD_CALIBRATE 32'hFFFF_FF15 // calibrate opcode
`define TCS_CMD_DL_BEGIN 32'hFFFF_FF00 // display list begin, no-op here
`define TCS_XFORM_ONE 32'h0001_0000 // 1.0 in 16.16 fixed point
`define TCS_XFORM_ZERO 32'h0000_0000
`define TCS_FRAC_BITS 16
`define TCS_NUM_POINTS 3
`define TCS_NUM_COEF 6
`define TCS_DIV_STEPS 7'h40 // one quotient bit per cycle over the dividend
// calibration targets on screen
`define TCS_TGT_X0 16'h0030
`define TCS_TGT_Y0 16'h0030
`define TCS_TGT_X1 16'h01B0
`define TCS_TGT_Y1 16'h0088
`define TCS_TGT_X2 16'h00F0
`define TCS_TGT_Y2 16'h00F0

`endif

// ==== shared/tcs_pkg.sv ====
// tcs_pkg: types of the touch calibration store
// assumes tcs_defs.svh carries all numeric constants
package tcs_pkg;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef logic signed [31:0] tcs_coef_t; // 16.16 transform word
   typedef logic [11:0] tcs_raw_t; // raw touch coordinate
   typedef logic [2:0] tcs_ptr_t; // command ring pointer

   typedef enum logic [2:0]
   {
      TCS_IDLE,
      TCS_EXEC,
      TCS_SHOW,
      TCS_RELEASE,
      TCS_NUM,
      TCS_DIV
   } tcs_state_e;

endpackage : tcs_pkg

// ==== rtl/tcs_divider.sv ====
// tcs_divider: sequential signed divider, 64-bit dividend by 32-bit divisor
// assumes divisor is nonzero and start is a one-cycle pulse while idle
`timescale 1ns/10ps
`default_nettype none
`include "tcs_defs.svh"

module tcs_divider
   import tcs_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic start_i,
   input wire logic signed [63:0] dividend_i,
   input wire logic signed [31:0] divisor_i,
   output logic done_o,
   output tcs_coef_t quot_o
);

   logic [63:0] dvd_q; // dividend magnitude, shifted out msb first
   logic [31:0] dsr_q; // divisor magnitude
   logic [32:0] rem_q; // partial remainder
   logic [63:0] quo_q; // quotient bits collected
   logic neg_q; // result sign
   logic [6:0] cnt_q; // remaining steps
   logic [32:0] rem_sh; // remainder after shift-in
   logic [63:0] quo_n; // quotient with this step's bit

   // one restoring step per cycle
   always_comb
   begin
      rem_sh = {rem_q[31:0], dvd_q[63]};
      quo_n = {quo_q[62:0], 1'b0};
      if (rem_sh >= {1'b0, dsr_q})
      begin
         quo_n[0] = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // iteration
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         dvd_q <= '0;
         dsr_q <= '0;
         rem_q <= '0;
         quo_q <= '0;
         neg_q <= 1'b0;
         cnt_q <= '0;
         done_o <= 1'b0;
         quot_o <= '0;
      end
      else
      begin
         done_o <= 1'b0;
         if (start_i)
         begin
            // work on magnitudes, sign restored at the end
            dvd_q <= dividend_i[63] ? 64'(-dividend_i) : dividend_i;
            dsr_q <= divisor_i[31] ? 32'(-divisor_i) : divisor_i;
            neg_q <= dividend_i[63] ^ divisor_i[31];
            rem_q <= '0;
            quo_q <= '0;
            cnt_q <= `TCS_DIV_STEPS;
         end
         else if (cnt_q != 7'h00)
         begin
            dvd_q <= {dvd_q[62:0], 1'b0};
            rem_q <= quo_n[0] ? 33'(rem_sh - {1'b0, dsr_q}) : rem_sh;
            quo_q <= quo_n;
            cnt_q <= cnt_q - 7'h01;
            if (cnt_q == 7'h01)
            begin
               // too-large quotients simply wrap; targets keep them small
               done_o <= 1'b1;
               quot_o <= neg_q ? 32'(-quo_n[31:0]) : quo_n[31:0];
            end
         end
      end
   end

endmodule // tcs_divider

`default_nettype wire

// ==== rtl/tcs_top.sv ====
// tcs_top: touch calibration store with command ring, three-point calibration and touch transform
// assumes a plain register port on ref_clk_i and raw touch pins from outside the clock domain
//
// Overview of operation
// - calibrate shows three targets, one tap each
// - six coefficients computed, each stored as its division completes
// - every touch corrected here by the coefficients
// - read pointer reaches write pointer after whole list
// - coefficients volatile, reset restores default values
// - calibrate in compatibility mode, keep for extended
// - host reads the six words back
// - host writes restore words, used like calibration
`timescale 1ns/10ps
`default_nettype none
`include "tcs_defs.svh"

module tcs_top
   import tcs_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire logic touch_press_i,
   input wire tcs_raw_t touch_raw_x_i,
   input wire tcs_raw_t touch_raw_y_i,
   output logic target_show_o,
   output logic [15:0] target_x_o,
   output logic [15:0] target_y_o,
   output logic touch_valid_o,
   output logic [15:0] touch_x_o,
   output logic [15:0] touch_y_o,
   output logic touch_ext_mode_o
);

   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   // numerator of one coefficient by cramer's rule; sel 0/1/2 = x/y/offset term
   function automatic logic signed [63:0] coef_num(input logic [1:0] sel,
      input logic [35:0] xs, input logic [35:0] ys, input logic [47:0] ts);
      logic signed [63:0] x0, x1, x2, y0, y1, y2, t0, t1, t2;
      x0 = 64'(xs[11:0]);
      x1 = 64'(xs[23:12]);
      x2 = 64'(xs[35:24]);
      y0 = 64'(ys[11:0]);
      y1 = 64'(ys[23:12]);
      y2 = 64'(ys[35:24]);
      t0 = 64'(ts[15:0]);
      t1 = 64'(ts[31:16]);
      t2 = 64'(ts[47:32]);
      unique case (sel)
         2'd0: coef_num = (t0 - t2) * (y1 - y2) - (t1 - t2) * (y0 - y2);
         2'd1: coef_num = (x0 - x2) * (t1 - t2) - (x1 - x2) * (t0 - t2);
         default: coef_num = t0 * (x1 * y2 - x2 * y1) - t1 * (x0 * y2 - x2 * y0)
            + t2 * (x0 * y1 - x1 * y0);
      endcase
   endfunction

   // one corrected axis: (p*rx + q*ry + r) in 16.16, integer part kept
   function automatic logic [15:0] apply_axis(input tcs_coef_t p, input tcs_coef_t q,
      input tcs_coef_t r, input tcs_raw_t rx, input tcs_raw_t ry);
      logic signed [63:0] acc;
      acc = 64'(p) * 64'(signed'({1'b0, rx})) + 64'(q) * 64'(signed'({1'b0, ry})) + 64'(r);
      apply_axis = acc[`TCS_FRAC_BITS +: 16];
   endfunction

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   tcs_coef_t xform_q [`TCS_NUM_COEF]; // transform words a..f
   logic [31:0] cmd_mem [8]; // command ring
   tcs_ptr_t rptr_q; // command read pointer
   tcs_ptr_t wptr_q; // command write pointer
   logic mode_ext_q; // extended touch mode request
   tcs_state_e state_q; // command engine state
   logic [1:0] pt_q; // current calibration target
   logic [2:0] k_q; // coefficient being computed
   logic [35:0] cal_x_q; // three raw x taps
   logic [35:0] cal_y_q; // three raw y taps
   logic [1:0] press_sync_q; // press synchroniser
   tcs_raw_t rx_s1_q, rx_s2_q, ry_s1_q, ry_s2_q; // raw coordinate synchronisers
   logic div_start_q; // divider start pulse
   logic signed [63:0] div_num_q; // dividend for divider
   logic signed [63:0] det_q; // determinant of the taps
   logic div_done;
   tcs_coef_t div_quot;
   logic [47:0] tgt_x; // target x set
   logic [47:0] tgt_y; // target y set
   logic signed [63:0] det_c; // determinant from taps
   logic [2:0] xidx; // transform index from address
   logic xsel; // address hits a transform word
   logic calibrating;

   assign tgt_x = {`TCS_TGT_X2, `TCS_TGT_X1, `TCS_TGT_X0};
   assign tgt_y = {`TCS_TGT_Y2, `TCS_TGT_Y1, `TCS_TGT_Y0};
   assign det_c = coef_num(2'd1, cal_x_q, cal_y_q, {4'h0, cal_y_q[35:24], 4'h0,
      cal_y_q[23:12], 4'h0, cal_y_q[11:0]});
   assign xidx = addr_i[4:2];
   assign xsel = (addr_i <= `TCS_OFS_XFORM_F) && (addr_i[1:0] == 2'b00);
   assign calibrating = (state_q == TCS_SHOW) || (state_q == TCS_RELEASE)
      || (state_q == TCS_NUM) || (state_q == TCS_DIV);

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   // two flops on every touch pin, data assumed steady while pressed
   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         press_sync_q <= 2'b00;
         rx_s1_q <= '0;
         rx_s2_q <= '0;
         ry_s1_q <= '0;
         ry_s2_q <= '0;
      end
      else
      begin
         press_sync_q <= {press_sync_q[0], touch_press_i};
         rx_s1_q <= touch_raw_x_i;
         rx_s2_q <= rx_s1_q;
         ry_s1_q <= touch_raw_y_i;
         ry_s2_q <= ry_s1_q;
      end
   end

   // ------------------------------------------------------------
   // register writes: pointer, mode, command ring
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         wptr_q <= '0;
         mode_ext_q <= 1'b0;
      end
      else if (wr_i)
      begin
         if (addr_i == `TCS_OFS_CMD_WRITE)
         begin
            wptr_q <= wdata_i[2:0];
         end
         if (addr_i == `TCS_OFS_TOUCH_MODE)
         begin
            mode_ext_q <= wdata_i[`TCS_MODE_EXT];
         end
      end
   end

   // command ring storage, no reset needed
   always_ff @(posedge ref_clk_i)
   begin
      if (wr_i && ((addr_i & `TCS_CMD_RAM_MASK) == `TCS_OFS_CMD_RAM))
      begin
         cmd_mem[addr_i[4:2]] <= wdata_i;
      end
   end

   // ------------------------------------------------------------
   // transform words
   // ------------------------------------------------------------
   // host write and calibration result share the store; a result landing
   // in the same cycle as a host write wins since it is the newer value
   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         // volatile: power-up always returns to identity
         for (int i = 0; i < `TCS_NUM_COEF; i++)
         begin
            xform_q[i] <= (i == 0 || i == 4) ? `TCS_XFORM_ONE : `TCS_XFORM_ZERO;
         end
      end
      else
      begin
         if (wr_i && xsel)
         begin
            xform_q[xidx] <= wdata_i;
         end
         if (state_q == TCS_DIV && div_done)
         begin
            xform_q[k_q] <= div_quot;
         end
      end
   end

   // ------------------------------------------------------------
   // command engine
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         state_q <= TCS_IDLE;
         rptr_q <= '0;
         pt_q <= '0;
         k_q <= '0;
         cal_x_q <= '0;
         cal_y_q <= '0;
         div_start_q <= 1'b0;
         div_num_q <= '0;
         det_q <= '0;
      end
      else
      begin
         div_start_q <= 1'b0;
         unique case (state_q)
            TCS_IDLE:
            begin
               // pending commands exist while pointers differ
               if (rptr_q != wptr_q)
               begin
                  state_q <= TCS_EXEC;
               end
            end
            TCS_EXEC:
            begin
               if (cmd_mem[rptr_q] == `TCS_CMD_CALIBRATE)
               begin
                  pt_q <= 2'd0;
                  state_q <= TCS_SHOW;
               end
               else
               begin
                  // other commands, display list begin among them, retire at once
                  rptr_q <= rptr_q + 3'd1;
                  state_q <= TCS_IDLE;
               end
            end
            TCS_SHOW:
            begin
               // one tap per target
               if (press_sync_q[1])
               begin
                  cal_x_q[pt_q * 12 +: 12] <= rx_s2_q;
                  cal_y_q[pt_q * 12 +: 12] <= ry_s2_q;
                  state_q <= TCS_RELEASE;
               end
            end
            TCS_RELEASE:
            begin
               // wait for lift so one long press is not taken as two taps
               if (!press_sync_q[1])
               begin
                  if (pt_q == 2'(`TCS_NUM_POINTS - 1))
                  begin
                     k_q <= '0;
                     det_q <= det_c;
                     state_q <= TCS_NUM;
                  end
                  else
                  begin
                     pt_q <= pt_q + 2'd1;
                     state_q <= TCS_SHOW;
                  end
               end
            end
            TCS_NUM:
            begin
               if (det_q == 64'sd0)
               begin
                  // collinear taps: old coefficients kept, command retires
                  rptr_q <= rptr_q + 3'd1;
                  state_q <= TCS_IDLE;
               end
               else
               begin
                  div_num_q <= coef_num(2'(k_q % 3), cal_x_q, cal_y_q,
                     (k_q < 3'd3) ? tgt_x : tgt_y) <<< `TCS_FRAC_BITS;
                  div_start_q <= 1'b1;
                  state_q <= TCS_DIV;
               end
            end
            TCS_DIV:
            begin
               if (div_done)
               begin
                  if (k_q == 3'(`TCS_NUM_COEF - 1))
                  begin
                     // list step done only after all six words are in
                     rptr_q <= rptr_q + 3'd1;
                     state_q <= TCS_IDLE;
                  end
                  else
                  begin
                     k_q <= k_q + 3'd1;
                     state_q <= TCS_NUM;
                  end
               end
            end
         endcase
      end
   end

   tcs_divider u_div
   (
      .ref_clk_i (ref_clk_i),
      .rstn_i (rstn_i),
      .start_i (div_start_q),
      .dividend_i (div_num_q),
      .divisor_i (det_q[31:0]),
      .done_o (div_done),
      .quot_o (div_quot)
   );

   // ------------------------------------------------------------
   // outputs: targets, corrected touch, mode
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         target_show_o <= 1'b0;
         target_x_o <= '0;
         target_y_o <= '0;
         touch_valid_o <= 1'b0;
         touch_x_o <= '0;
         touch_y_o <= '0;
         touch_ext_mode_o <= 1'b0;
      end
      else
      begin
         target_show_o <= (state_q == TCS_SHOW);
         target_x_o <= tgt_x[pt_q * 16 +: 16];
         target_y_o <= tgt_y[pt_q * 16 +: 16];
         // compatibility mode forced while calibrating, same words used after
         touch_ext_mode_o <= mode_ext_q && !calibrating;
         // touch valid is held low for the whole calibration, taps and rebuild alike; coordinates still update
         touch_valid_o <= press_sync_q[1] && !calibrating;
         if (press_sync_q[1])
         begin
            touch_x_o <= apply_axis(xform_q[0], xform_q[1], xform_q[2], rx_s2_q, ry_s2_q);
            touch_y_o <= apply_axis(xform_q[3], xform_q[4], xform_q[5], rx_s2_q, ry_s2_q);
         end
      end
   end

   // ------------------------------------------------------------
   // register reads, data one cycle after the strobe
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rdata_o <= '0;
      end
      else if (rd_i)
      begin
         if (xsel)
         begin
            rdata_o <= xform_q[xidx];
         end
         else if (addr_i == `TCS_OFS_CMD_READ)
         begin
            rdata_o <= {29'h0, rptr_q};
         end
         else if (addr_i == `TCS_OFS_CMD_WRITE)
         begin
            rdata_o <= {29'h0, wptr_q};
         end
         else if (addr_i == `TCS_OFS_TOUCH_MODE)
         begin
            rdata_o <= {31'h0, mode_ext_q};
         end
         else if (addr_i == `TCS_OFS_STATUS)
         begin
            rdata_o <= {28'h0, pt_q, calibrating, (state_q != TCS_IDLE)};
         end
         else if (addr_i == `TCS_OFS_TOUCH_XY)
         begin
            rdata_o <= {touch_y_o, touch_x_o};
         end
         else
         begin
            // command ring is write only; unmapped reads give zero
            rdata_o <= '0;
         end
      end
      else
      begin
         rdata_o <= '0;
      end
   end

endmodule // tcs_top

`default_nettype wire

// ==== verification/tcs_checker.sv ====
// tcs_checker: port-level assertions for the touch calibration store
// assumes one clock domain and an active-low asynchronous reset
`timescale 1ns/10ps
`default_nettype none
`include "tcs_defs.svh"

module tcs_checker
(
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic touch_press_i,
   input wire logic target_show_o,
   input wire logic [15:0] target_x_o,
   input wire logic [15:0] target_y_o,
   input wire logic touch_valid_o,
   input wire logic [15:0] touch_x_o,
   input wire logic [15:0] touch_y_o,
   input wire logic touch_ext_mode_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rstn_i);

   // finger off the panel long enough for the sync chain to drain
   sequence s_lifted;
      !touch_press_i [*4];
   endsequence

   // a press reached the pin two to four edges ago
   sequence s_recent_press;
      $past(touch_press_i, 2) || $past(touch_press_i, 3) || $past(touch_press_i, 4);
   endsequence

   a_rdata_zero_idle: assert property (!rd_i |=> rdata_o == 32'h0000_0000)
      else $error("read data not zero outside the read answer cycle");
   a_target_no_valid: assert property (target_show_o |-> !touch_valid_o)
      else $error("touch reported while a target waits");
   a_target_no_ext: assert property (target_show_o |-> !touch_ext_mode_o)
      else $error("extended mode active during calibration");
   a_target_drop_tap: assert property ($fell(target_show_o) |-> s_recent_press)
      else $error("target removed without a tap");
   a_target_steady: assert property ($past(target_show_o) && target_show_o |->
      $stable(target_x_o) && $stable(target_y_o))
      else $error("target moved while shown");
   a_target_legal: assert property (target_show_o |->
      (target_x_o == `TCS_TGT_X0 && target_y_o == `TCS_TGT_Y0) ||
      (target_x_o == `TCS_TGT_X1 && target_y_o == `TCS_TGT_Y1) ||
      (target_x_o == `TCS_TGT_X2 && target_y_o == `TCS_TGT_Y2))
      else $error("target at an unknown place");
   a_valid_has_press: assert property (touch_valid_o |-> s_recent_press)
      else $error("touch valid without a press");
   a_xy_hold_lifted: assert property (s_lifted |=>
      $stable(touch_x_o) && $stable(touch_y_o))
      else $error("corrected touch changed with no press");
endmodule // tcs_checker

bind tcs_top tcs_checker i_tcs_checker
(
   .ref_clk_i,
   .rstn_i,
   .rd_i,
   .rdata_o,
   .touch_press_i,
   .target_show_o,
   .target_x_o,
   .target_y_o,
   .touch_valid_o,
   .touch_x_o,
   .touch_y_o,
   .touch_ext_mode_o
);
`default_nettype wire

// ==== verification/tcs_panel_model.sv ====
// tcs_panel_model: behavioural touch panel with a finger
// assumes the store samples the raw pins on ref_clk_i
`timescale 1ns/10ps
`default_nettype none

module tcs_panel_model
(
   input wire logic ref_clk_i,
   output logic press_o,
   output logic [11:0] raw_x_o,
   output logic [11:0] raw_y_o
);
   initial
   begin
      press_o = 1'b0;
      raw_x_o = 12'h000;
      raw_y_o = 12'h000;
   end

   // one tap; coordinates steady while pressed, scrambled once lifted
   // so a stale value can never pass for a real one
   task automatic tap(input logic [11:0] x, input logic [11:0] y);
   begin
      @(posedge ref_clk_i);
      press_o <= 1'b1;
      raw_x_o <= x;
      raw_y_o <= y;
      repeat (12) @(posedge ref_clk_i);
      press_o <= 1'b0;
      raw_x_o <= ~x;
      raw_y_o <= ~y;
      repeat (12) @(posedge ref_clk_i);
   end
   endtask
endmodule // tcs_panel_model
`default_nettype wire

// ==== verification/tb_top.sv ====
// tb_top: self-checking bench for the touch calibration store
// assumes the panel model on the touch pins and a checker bound in
`timescale 1ns/10ps
`default_nettype none
`include "tcs_defs.svh"

module tb_top;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic [31:0] got;
   logic press, show, tvalid, ext;
   logic [11:0] rx, ry;
   logic [15:0] tx, ty, cx, cy;
   int num_errors = 0;
   int checks_done = 0;
   logic [7:0] nv [25]; // host non-volatile store: marker byte, then 24 coefficient bytes
   // restore words and expected calibration result (panel offset +0x20, +0x10)
   localparam logic [31:0] RST [6] = '{32'h0002_0000, 32'h0000_0000, 32'h0005_0000,
      32'h0000_0000, 32'h0001_0000, 32'hFFFF_0000};
   localparam logic [31:0] CAL [6] = '{32'h0001_0000, 32'h0000_0000, 32'hFFE0_0000,
      32'h0000_0000, 32'h0001_0000, 32'hFFF0_0000};
   localparam logic [31:0] TGT [3] = '{{`TCS_TGT_X0, `TCS_TGT_Y0},
      {`TCS_TGT_X1, `TCS_TGT_Y1}, {`TCS_TGT_X2, `TCS_TGT_Y2}};

   initial
   begin
      forever #5 clk = ~clk;
   end

   tcs_top i_tcs_top (.ref_clk_i(clk), .rstn_i(rstn), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .touch_press_i(press), .touch_raw_x_i(rx),
      .touch_raw_y_i(ry), .target_show_o(show), .target_x_o(tx), .target_y_o(ty),
      .touch_valid_o(tvalid), .touch_x_o(cx), .touch_y_o(cy), .touch_ext_mode_o(ext));
   tcs_panel_model i_panel (.ref_clk_i(clk), .press_o(press), .raw_x_o(rx), .raw_y_o(ry));

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
   begin
      checks_done++;
      if (g !== e)
      begin
         num_errors++;
         $display("mismatch %0t: got %h exp %h", $time, g, e);
      end
   end
   endtask

   // strobe for one edge, then one idle edge so a following call never
   // reassigns the strobe in the same time step; called right after an edge
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
   begin
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   end
   endtask

   // read data stands only in the cycle after the strobe: taken at its closing edge
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
   begin
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      d = rdata;
   end
   endtask

   task automatic touch(input logic [11:0] x, y, input logic [15:0] ex, ey);
   begin
      fork
         i_panel.tap(x, y);
         begin
            repeat (8) @(posedge clk);
            chk(tvalid, 1'b1);
            chk({cx, cy}, {ex, ey});
         end
      join
      // the corrected point stays readable after the finger lifts
      rd_reg(`TCS_OFS_TOUCH_XY, got);
      chk(got, {ey, ex});
   end
   endtask

   task automatic t_defaults();
   begin
      for (int i = 0; i < 6; i++)
      begin
         rd_reg(8'(4 * i), got);
         chk(got, (i == 0 || i == 4) ? `TCS_XFORM_ONE : `TCS_XFORM_ZERO);
      end
      wr_reg(`TCS_OFS_CMD_READ, 32'h0000_0005);
      rd_reg(`TCS_OFS_CMD_READ, got);
      chk(got, 32'h0000_0000);
      rd_reg(8'h30, got);
      chk(got, 32'h0000_0000);
   end
   endtask

   task automatic t_restore();
   begin
      for (int i = 0; i < 6; i++)
         wr_reg(8'(4 * i), RST[i]);
      wr_reg(`TCS_OFS_TOUCH_MODE, 32'h0000_0001);
      for (int i = 0; i < 6; i++)
      begin
         rd_reg(8'(4 * i), got);
         chk(got, RST[i]);
      end
      chk(ext, 1'b1);
      touch(12'h100, 12'h080, 16'h0205, 16'h007F);
   end
   endtask

   task automatic t_calibrate();
      int n;
   begin
      chk(press, 1'b0);
      wr_reg(8'h40, `TCS_CMD_DL_BEGIN);
      wr_reg(8'h44, `TCS_CMD_CALIBRATE);
      wr_reg(`TCS_OFS_CMD_WRITE, 32'h0000_0002);
      for (int p = 0; p < 3; p++)
      begin
         n = 0;
         while (!show && n < 300)
         begin
            @(posedge clk);
            n++;
         end
         chk(show, 1'b1);
         chk({tx, ty}, TGT[p]);
         rd_reg(`TCS_OFS_CMD_READ, got);
         chk(got, 32'h0000_0001);
         rd_reg(`TCS_OFS_STATUS, got);
         chk(got, 32'(4 * p + 3));
         i_panel.tap(tx[11:0] + 12'h020, ty[11:0] + 12'h010);
      end
      n = 0;
      while (got !== 32'h0000_0002 && n < 200)
      begin
         repeat (10) @(posedge clk);
         rd_reg(`TCS_OFS_CMD_READ, got);
         n++;
      end
      chk(got, 32'h0000_0002);
      for (int i = 0; i < 6; i++)
      begin
         rd_reg(8'(4 * i), got);
         chk(got, CAL[i]);
         // host saves each word byte by byte, lowest byte first
         {nv[4 * i + 4], nv[4 * i + 3], nv[4 * i + 2], nv[4 * i + 1]} = got;
      end
      nv[0] = 8'h7C;
      chk(ext, 1'b1);
      touch(12'h120, 12'h040, 16'h0100, 16'h0030);
   end
   endtask

   // power loss returns the words to identity; the host brings them back from its own store
   task automatic t_power_cycle();
   begin
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      t_defaults();
      // restore only with a saved set and no finger on the panel
      if (!press && nv[0] === 8'h7C)
      begin
         for (int i = 0; i < 6; i++)
         begin
            wr_reg(8'(4 * i), {nv[4 * i + 4], nv[4 * i + 3], nv[4 * i + 2], nv[4 * i + 1]});
         end
      end
      for (int i = 0; i < 6; i++)
      begin
         rd_reg(8'(4 * i), got);
         chk(got, CAL[i]);
      end
      touch(12'h120, 12'h040, 16'h0100, 16'h0030);
   end
   endtask

   task automatic end_of_test();
   begin
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   end
   endtask

   // watchdog: the run needs a few thousand cycles at most
   initial
   begin
      #200000;
      num_errors++;
      end_of_test();
   end

   initial
   begin
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      t_defaults();
      t_restore();
      t_calibrate();
      t_power_cycle();
      end_of_test();
   end
endmodule // tb_top
`default_nettype wire
